/* logic/fsic_cfg.svh */
// Constants for the flash suspend and interrupt controller
`ifndef FSIC_CFG_SVH
`define FSIC_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FSIC_CLK_NS 5
`define FSIC_SUSP_NS 50
`define FSIC_ABORT_NS 80
`define FSIC_SUSP_CYC (((`FSIC_SUSP_NS + `FSIC_CLK_NS - 1) / `FSIC_CLK_NS) < 1 ? 1 : \
   ((`FSIC_SUSP_NS + `FSIC_CLK_NS - 1) / `FSIC_CLK_NS))
`define FSIC_ABORT_CYC (((`FSIC_ABORT_NS + `FSIC_CLK_NS - 1) / `FSIC_CLK_NS) < 1 ? 1 : \
   ((`FSIC_ABORT_NS + `FSIC_CLK_NS - 1) / `FSIC_CLK_NS))
`define FSIC_TW 8

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define FSIC_AW 8
`define FSIC_OFF_CTRL 8'h00
`define FSIC_OFF_SUSP 8'h04
`define FSIC_OFF_CMD 8'h08
`define FSIC_OFF_STAT 8'h0c

// Control fields
`define FSIC_CTRL_MODE1 0
`define FSIC_CTRL_ESUS_EN 1
`define FSIC_CTRL_PSUS_EN 2
`define FSIC_CTRL_REW_LSB 3
`define FSIC_REW_N 3

// Suspend control fields
`define FSIC_SUSP_EREQ 1
`define FSIC_SUSP_PREQ 2

// Command fields
`define FSIC_CMD_ERASE 0
`define FSIC_CMD_PROG 1

// Status fields
`define FSIC_STAT_BUSY 0
`define FSIC_STAT_SUSP 1
`define FSIC_STAT_ABT 2
`define FSIC_STAT_ABF 3
`define FSIC_STAT_HOLD 4

`endif

/* logic/fsic_pkg.sv */
// Types for the flash suspend and interrupt controller
package fsic_pkg;

   typedef enum logic [2:0] {
      FSIC_IDLE = 3'h0,
      FSIC_RUN = 3'h1,
      FSIC_SUSP_WAIT = 3'h2,
      FSIC_SUSPENDED = 3'h3,
      FSIC_ABORT = 3'h4
   } fsic_state_t;

   typedef enum logic {
      FSIC_OP_ERASE = 1'h0,
      FSIC_OP_PROG = 1'h1
   } fsic_op_t;

endpackage

/* logic/fsic_delay_timer.sv */
// Down counter that pulses done a set number of cycles after start
`timescale 1ns/100ps
module fsic_delay_timer #(
   parameter int TW = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic cancel,
   input wire logic [TW-1:0] len,
   output logic busy,
   output logic done
);

   logic [TW-1:0] cnt_r;
   logic [TW-1:0] cnt_nxt;

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   always_comb begin
      cnt_nxt = cnt_r;
      if (cancel) begin
         cnt_nxt = '0;
      end else if (start) begin
         cnt_nxt = len;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - TW'(1);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign busy = (cnt_r != '0);
   // Last counted cycle; a length of one finishes in the cycle after start
   assign done = (cnt_r == TW'(1)) && !cancel;

endmodule

/* logic/fsic_ctrl.sv */
// Flash erase and program sequencer with suspend and forced abort
`timescale 1ns/100ps
`include "fsic_cfg.svh"

// How it works
// - A maskable interrupt during an erase with erase suspension on suspends the erase after the suspend delay, then lets handling run.
// - With erase suspension off, the erase goes on and maskable handling waits until it completes.
// - A maskable interrupt during programming with program suspension on suspends it after the suspend delay, then lets handling run.
// - With program suspension off, programming goes on and maskable handling waits until it completes.
// - A safety interrupt during an erase or program aborts it at once, resets the flash, and handling starts after a fixed period with a flash restart.
module fsic_ctrl import fsic_pkg::*; #(
   parameter int SUSP_CYC = `FSIC_SUSP_CYC,
   parameter int ABORT_CYC = `FSIC_ABORT_CYC,
   parameter int TW = `FSIC_TW
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [`FSIC_AW-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic flash_done,
   input wire logic irq_maskable_req,
   input wire logic irq_safety_req,
   output logic flash_erase_run,
   output logic flash_prog_run,
   output logic flash_suspend,
   output logic flash_reset,
   output logic flash_restart,
   output logic maskable_allow,
   output logic safety_allow,
   output logic [`FSIC_REW_N-1:0] rewrite_en
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   fsic_state_t state_r, state_nxt;
   fsic_op_t op_r, op_nxt;
   logic ereq_r, ereq_nxt;
   logic preq_r, preq_nxt;
   logic abf_r, abf_nxt;
   logic flash_reset_r, flash_reset_nxt;
   logic flash_restart_r, flash_restart_nxt;
   logic mode1_r, mode1_nxt;
   logic esus_en_r, esus_en_nxt;
   logic psus_en_r, psus_en_nxt;
   logic [`FSIC_REW_N-1:0] rew_r, rew_nxt;
   logic [`FSIC_REW_N-1:0] arm_r, arm_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic wr_ctrl, wr_susp, wr_cmd, wr_stat;
   logic sus_start, sus_cancel, sus_done;
   logic abt_start, abt_done;
   logic cur_susp_en, cur_req, active, hold;

   assign wr_ctrl = reg_wr && (reg_addr == `FSIC_OFF_CTRL);
   assign wr_susp = reg_wr && (reg_addr == `FSIC_OFF_SUSP);
   assign wr_cmd = reg_wr && (reg_addr == `FSIC_OFF_CMD);
   assign wr_stat = reg_wr && (reg_addr == `FSIC_OFF_STAT);

   assign cur_susp_en = (op_r == FSIC_OP_ERASE) ? esus_en_r : psus_en_r;
   assign cur_req = (op_r == FSIC_OP_ERASE) ? ereq_r : preq_r;
   assign active = (state_r == FSIC_RUN) || (state_r == FSIC_SUSP_WAIT) || (state_r == FSIC_SUSPENDED);

   // ----------------------------------------------------------------
   // Timers
   // ----------------------------------------------------------------
   fsic_delay_timer #(.TW(TW)) u_susp_tmr (
      .core_clk(core_clk),
      .rst(rst),
      .start(sus_start),
      .cancel(sus_cancel),
      .len(TW'(SUSP_CYC)),
      .busy(),
      .done(sus_done)
   );

   fsic_delay_timer #(.TW(TW)) u_abt_tmr (
      .core_clk(core_clk),
      .rst(rst),
      .start(abt_start),
      .cancel(1'h0),
      .len(TW'(ABORT_CYC)),
      .busy(),
      .done(abt_done)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      op_nxt = op_r;
      ereq_nxt = ereq_r;
      preq_nxt = preq_r;
      abf_nxt = abf_r;
      flash_reset_nxt = 1'h0;
      flash_restart_nxt = 1'h0;
      sus_start = 1'h0;
      sus_cancel = 1'h0;
      abt_start = 1'h0;
      if (wr_susp && !reg_wdata[`FSIC_SUSP_EREQ]) begin
         ereq_nxt = 1'h0;
      end
      if (wr_susp && !reg_wdata[`FSIC_SUSP_PREQ]) begin
         preq_nxt = 1'h0;
      end
      if (wr_stat && reg_wdata[`FSIC_STAT_ABF]) begin
         abf_nxt = 1'h0;
      end
      case (state_r)
         FSIC_IDLE: begin
            if (wr_cmd && mode1_r && reg_wdata[`FSIC_CMD_ERASE]) begin
               state_nxt = FSIC_RUN;
               op_nxt = FSIC_OP_ERASE;
            end else if (wr_cmd && mode1_r && reg_wdata[`FSIC_CMD_PROG]) begin
               state_nxt = FSIC_RUN;
               op_nxt = FSIC_OP_PROG;
            end
         end
         FSIC_RUN: begin
            if (irq_safety_req) begin
               state_nxt = FSIC_ABORT;
            end else if (flash_done) begin
               state_nxt = FSIC_IDLE;
            end else if (irq_maskable_req && cur_susp_en) begin
               state_nxt = FSIC_SUSP_WAIT;
               sus_start = 1'h1;
            end
         end
         FSIC_SUSP_WAIT: begin
            if (irq_safety_req) begin
               state_nxt = FSIC_ABORT;
               sus_cancel = 1'h1;
            end else if (flash_done) begin
               state_nxt = FSIC_IDLE;
               sus_cancel = 1'h1;
            end else if (sus_done) begin
               state_nxt = FSIC_SUSPENDED;
               if (op_r == FSIC_OP_ERASE) begin
                  ereq_nxt = 1'h1;
               end else begin
                  preq_nxt = 1'h1;
               end
            end
         end
         FSIC_SUSPENDED: begin
            if (irq_safety_req) begin
               state_nxt = FSIC_ABORT;
            end else if (!cur_req) begin
               state_nxt = FSIC_RUN;
            end
         end
         FSIC_ABORT: begin
            if (abt_done) begin
               state_nxt = FSIC_IDLE;
               flash_restart_nxt = 1'h1;
            end
         end
         default: begin
            state_nxt = FSIC_IDLE;
         end
      endcase
      if (active && irq_safety_req) begin
         flash_reset_nxt = 1'h1;
         abt_start = 1'h1;
         abf_nxt = 1'h1;
         ereq_nxt = 1'h0;
         preq_nxt = 1'h0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r <= FSIC_IDLE;
         op_r <= FSIC_OP_ERASE;
         ereq_r <= 1'h0;
         preq_r <= 1'h0;
         abf_r <= 1'h0;
         flash_reset_r <= 1'h0;
         flash_restart_r <= 1'h0;
      end else begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         ereq_r <= ereq_nxt;
         preq_r <= preq_nxt;
         abf_r <= abf_nxt;
         flash_reset_r <= flash_reset_nxt;
         flash_restart_r <= flash_restart_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign flash_erase_run = (op_r == FSIC_OP_ERASE) && ((state_r == FSIC_RUN) || (state_r == FSIC_SUSP_WAIT));
   assign flash_prog_run = (op_r == FSIC_OP_PROG) && ((state_r == FSIC_RUN) || (state_r == FSIC_SUSP_WAIT));
   assign flash_suspend = (state_r == FSIC_SUSPENDED);
   assign flash_reset = flash_reset_r;
   assign flash_restart = flash_restart_r;
   // handling only when flash idle or suspended
   assign maskable_allow = (state_r == FSIC_IDLE) || (state_r == FSIC_SUSPENDED);
   assign safety_allow = (state_r != FSIC_ABORT);
   assign hold = irq_maskable_req && !maskable_allow;
   assign rewrite_en = rew_r;

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always_comb begin
      mode1_nxt = mode1_r;
      esus_en_nxt = esus_en_r;
      psus_en_nxt = psus_en_r;
      rew_nxt = rew_r;
      arm_nxt = arm_r;
      if (wr_ctrl) begin
         mode1_nxt = reg_wdata[`FSIC_CTRL_MODE1];
         esus_en_nxt = reg_wdata[`FSIC_CTRL_ESUS_EN];
         psus_en_nxt = reg_wdata[`FSIC_CTRL_PSUS_EN];
         // one only after a zero write
         for (int i = 0; i < `FSIC_REW_N; i++) begin
            if (!reg_wdata[`FSIC_CTRL_REW_LSB + i]) begin
               rew_nxt[i] = 1'h0;
               arm_nxt[i] = 1'h1;
            end else if (arm_r[i]) begin
               rew_nxt[i] = 1'h1;
               arm_nxt[i] = 1'h0;
            end
         end
      end
      // Accepted maskable interrupt between the two writes breaks the sequence
      if (irq_maskable_req && maskable_allow) begin
         arm_nxt = '0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode1_r <= 1'h0;
         esus_en_r <= 1'h0;
         psus_en_r <= 1'h0;
         rew_r <= '0;
         arm_r <= '0;
      end else begin
         mode1_r <= mode1_nxt;
         esus_en_r <= esus_en_nxt;
         psus_en_r <= psus_en_nxt;
         rew_r <= rew_nxt;
         arm_r <= arm_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      rdata_nxt = '0;
      if (reg_rd) begin
         case (reg_addr)
            `FSIC_OFF_CTRL: begin
               rdata_nxt[`FSIC_CTRL_MODE1] = mode1_r;
               rdata_nxt[`FSIC_CTRL_ESUS_EN] = esus_en_r;
               rdata_nxt[`FSIC_CTRL_PSUS_EN] = psus_en_r;
               rdata_nxt[`FSIC_CTRL_REW_LSB +: `FSIC_REW_N] = rew_r;
            end
            `FSIC_OFF_SUSP: begin
               rdata_nxt[`FSIC_SUSP_EREQ] = ereq_r;
               rdata_nxt[`FSIC_SUSP_PREQ] = preq_r;
            end
            `FSIC_OFF_STAT: begin
               rdata_nxt[`FSIC_STAT_BUSY] = active;
               rdata_nxt[`FSIC_STAT_SUSP] = flash_suspend;
               rdata_nxt[`FSIC_STAT_ABT] = (state_r == FSIC_ABORT);
               rdata_nxt[`FSIC_STAT_ABF] = abf_r;
               rdata_nxt[`FSIC_STAT_HOLD] = hold;
            end
            default: begin
               rdata_nxt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Cycles of the abort period between the reset cycle and the restart cycle
   localparam int ABT_HOLD = ABORT_CYC - 1;
   logic [TW-1:0] wcnt_r;

   // Counts cycles spent waiting for the suspend point
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wcnt_r <= '0;
      end else if (state_r == FSIC_SUSP_WAIT) begin
         wcnt_r <= wcnt_r + TW'(1);
      end else begin
         wcnt_r <= '0;
      end
   end

   sequence s_susp_trig;
      state_r == FSIC_RUN && irq_maskable_req && cur_susp_en && !irq_safety_req && !flash_done;
   endsequence

   sequence s_enter_susp;
      state_r == FSIC_SUSPENDED && $past(state_r) == FSIC_SUSP_WAIT;
   endsequence

   a_erase_susp_go: assert property (@(posedge core_clk) disable iff (rst)
      s_susp_trig and op_r == FSIC_OP_ERASE |=> state_r == FSIC_SUSP_WAIT && !maskable_allow)
      else $error("erase suspend not started");

   a_prog_susp_go: assert property (@(posedge core_clk) disable iff (rst)
      s_susp_trig and op_r == FSIC_OP_PROG |=> state_r == FSIC_SUSP_WAIT && flash_prog_run)
      else $error("program suspend not started");

   a_susp_delay_len: assert property (@(posedge core_clk) disable iff (rst)
      s_enter_susp |-> $past(wcnt_r) == TW'(SUSP_CYC - 1) && maskable_allow)
      else $error("suspend delay length wrong");

   // suspend bit marks the suspended erase
   a_erase_req_set: assert property (@(posedge core_clk) disable iff (rst)
      s_enter_susp and op_r == FSIC_OP_ERASE |-> ereq_r && !preq_r)
      else $error("erase suspend bit not set");

   a_prog_resume: assert property (@(posedge core_clk) disable iff (rst)
      state_r == FSIC_SUSPENDED && op_r == FSIC_OP_PROG && !preq_r && !irq_safety_req
      |=> state_r == FSIC_RUN && flash_prog_run)
      else $error("program not resumed");

   a_erase_hold: assert property (@(posedge core_clk) disable iff (rst)
      state_r == FSIC_RUN && op_r == FSIC_OP_ERASE && !esus_en_r && irq_maskable_req && !flash_done
      && !irq_safety_req |=> state_r == FSIC_RUN && !maskable_allow)
      else $error("erase did not hold interrupt");

   a_prog_done_allow: assert property (@(posedge core_clk) disable iff (rst)
      state_r == FSIC_RUN && !psus_en_r && flash_done && !irq_safety_req |=> maskable_allow)
      else $error("interrupt not allowed after program");

   a_abort_reset: assert property (@(posedge core_clk) disable iff (rst)
      active && irq_safety_req |=> flash_reset && !flash_erase_run && !flash_prog_run && !safety_allow)
      else $error("abort did not reset flash");

   a_abort_period: assert property (@(posedge core_clk) disable iff (rst)
      flash_reset |-> (!safety_allow throughout ##ABT_HOLD 1'b1) ##1 (flash_restart && safety_allow))
      else $error("abort period wrong");

endmodule

/* testbench/fsic_flash_model.sv */
// Flash array model that completes an operation after a set number of active cycles
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Flash array
// ----------------------------------------------------------------
module fsic_flash_model #(
   parameter int DONE_LEN = 40
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic erase_run,
   input wire logic prog_run,
   input wire logic flash_reset,
   output logic flash_done
);
   logic [7:0] cnt_r;
   // completion pulse
   // Count holds while suspended, so a resumed operation ends late, as a real array would
   // array reset drops progress
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 8'h00;
         flash_done <= 1'h0;
      end else if (flash_reset || flash_done) begin
         cnt_r <= 8'h00;
         flash_done <= 1'h0;
      end else begin
         if (erase_run || prog_run) begin
            cnt_r <= cnt_r + 8'h01;
         end
         flash_done <= (erase_run || prog_run) && (cnt_r == 8'(DONE_LEN - 1));
      end
   end
endmodule

/* testbench/flash_suspend_interrupt_ctrl_tb.sv */
// Self-checking bench for the flash suspend and interrupt controller
`timescale 1ns/100ps
`include "fsic_cfg.svh"

module flash_suspend_interrupt_ctrl_tb;
   localparam int SUSP = 4;
   localparam int ABRT = 6;
   logic core_clk, rst, reg_wr, reg_rd, flash_done, irq_maskable_req, irq_safety_req;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic erase_run, prog_run, flash_suspend, flash_reset, flash_restart, maskable_allow, safety_allow;
   logic [2:0] rewrite_en;
   int failures, tests_run, n, i;

   // ----------------------------------------------------------------
   // Design and flash model
   // ----------------------------------------------------------------
   fsic_ctrl #(.SUSP_CYC(SUSP), .ABORT_CYC(ABRT), .TW(8)) DUT (.core_clk(core_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .flash_done(flash_done), .irq_maskable_req(irq_maskable_req), .irq_safety_req(irq_safety_req),
      .flash_erase_run(erase_run), .flash_prog_run(prog_run), .flash_suspend(flash_suspend),
      .flash_reset(flash_reset), .flash_restart(flash_restart), .maskable_allow(maskable_allow),
      .safety_allow(safety_allow), .rewrite_en(rewrite_en));
   fsic_flash_model #(.DONE_LEN(40)) flash (.core_clk(core_clk), .rst(rst), .erase_run(erase_run),
      .prog_run(prog_run), .flash_reset(flash_reset), .flash_done(flash_done));

   always #2.5 core_clk = ~core_clk;

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Idle cycle after each write keeps the strobe from being driven twice in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge core_clk);
      reg_wr <= 1'h0;
      @(posedge core_clk);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      @(posedge core_clk);
      chk(reg_rdata, exp);
   endtask

   task automatic end_of_test;
      $display("Checks run %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // One erase or program, with or without suspension, maskable request raised at once
   task automatic run_op(input logic prog, input logic susp);
      int k;
      wr(`FSIC_OFF_CTRL, 32'h1 | (susp ? (prog ? 32'h4 : 32'h2) : 32'h0));
      wr(`FSIC_OFF_CMD, prog ? 32'h2 : 32'h1);
      chk(prog ? prog_run : erase_run, 32'h1);
      chk(maskable_allow, 32'h0);
      irq_maskable_req <= 1'h1;
      if (susp) begin
         k = 0;
         while (flash_suspend !== 1'h1 && k < 50) begin
            @(posedge core_clk);
            k++;
         end
         chk(32'(k), 32'(SUSP + 2));
         chk(maskable_allow, 32'h1);
         chk(erase_run | prog_run, 32'h0);
         irq_maskable_req <= 1'h0;
         rd_chk(`FSIC_OFF_SUSP, prog ? 32'h4 : 32'h2);
         wr(`FSIC_OFF_SUSP, 32'h0);
         // Resume shows one cycle after the clear lands
         @(posedge core_clk);
         chk(prog ? prog_run : erase_run, 32'h1);
         chk(flash_suspend, 32'h0);
      end else begin
         rd_chk(`FSIC_OFF_STAT, 32'h11);
      end
      k = 0;
      while ((erase_run | prog_run) === 1'h1 && k < 200) begin
         chk(maskable_allow, 32'h0);
         chk(flash_suspend, 32'h0);
         @(posedge core_clk);
         k++;
      end
      chk(maskable_allow, 32'h1);
      irq_maskable_req <= 1'h0;
      rd_chk(`FSIC_OFF_STAT, 32'h0);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'h0;
      rst = 1'h1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      irq_maskable_req = 1'h0;
      irq_safety_req = 1'h0;
      failures = 0;
      tests_run = 0;
      repeat (16) @(posedge core_clk);
      rst <= 1'h0;
      @(posedge core_clk);
      chk(maskable_allow, 32'h1);
      chk(safety_allow, 32'h1);
      for (i = 0; i < 5; i++) begin
         rd_chk(8'(i * 4), 32'h0);
      end
      // Unmapped writes and commands without the mode bit have no effect
      wr(8'h10, 32'hffffffff);
      rd_chk(`FSIC_OFF_CTRL, 32'h0);
      wr(`FSIC_OFF_CMD, 32'h1);
      chk(erase_run, 32'h0);
      wr(`FSIC_OFF_CTRL, 32'h0);
      wr(`FSIC_OFF_CTRL, 32'h38);
      chk({29'h0, rewrite_en}, 32'h7);
      rd_chk(`FSIC_OFF_CTRL, 32'h38);
      wr(`FSIC_OFF_CTRL, 32'h0);
      irq_maskable_req <= 1'h1;
      @(posedge core_clk);
      irq_maskable_req <= 1'h0;
      wr(`FSIC_OFF_CTRL, 32'h38);
      chk({29'h0, rewrite_en}, 32'h0);
      wr(`FSIC_OFF_CTRL, 32'h38);
      chk({29'h0, rewrite_en}, 32'h0);
      // Every operation with suspension on and off
      for (i = 0; i < 4; i++) begin
         run_op(i[0], i[1]);
      end
      // Safety request while idle is ignored
      irq_safety_req <= 1'h1;
      repeat (3) begin
         @(posedge core_clk);
         chk(flash_reset, 32'h0);
      end
      irq_safety_req <= 1'h0;
      wr(`FSIC_OFF_CTRL, 32'h3);
      wr(`FSIC_OFF_CMD, 32'h1);
      @(posedge core_clk);
      irq_safety_req <= 1'h1;
      for (n = 1; n <= ABRT + 2; n++) begin
         @(posedge core_clk);
         irq_safety_req <= 1'h0;
         chk(flash_reset, 32'(n == 2));
         chk(flash_restart, 32'(n == ABRT + 2));
         chk(safety_allow, 32'(n == 1 || n == ABRT + 2));
         chk(erase_run, 32'(n == 1));
      end
      rd_chk(`FSIC_OFF_STAT, 32'h8);
      wr(`FSIC_OFF_STAT, 32'h8);
      rd_chk(`FSIC_OFF_STAT, 32'h0);
      wr(`FSIC_OFF_CTRL, 32'h3);
      wr(`FSIC_OFF_CMD, 32'h1);
      irq_maskable_req <= 1'h1;
      repeat (SUSP + 2) @(posedge core_clk);
      chk(flash_suspend, 32'h1);
      irq_maskable_req <= 1'h0;
      irq_safety_req <= 1'h1;
      @(posedge core_clk);
      irq_safety_req <= 1'h0;
      @(posedge core_clk);
      chk(flash_reset, 32'h1);
      rd_chk(`FSIC_OFF_SUSP, 32'h0);
      rd_chk(`FSIC_OFF_STAT, 32'hc);
      wr(`FSIC_OFF_STAT, 32'h8);
      rd_chk(`FSIC_OFF_STAT, 32'h0);
      run_op(1'h0, 1'h0);
      end_of_test;
   end

   // Whole run is a few hundred cycles; this cuts a hang well beyond that
   initial begin
      #(20000 * 5);
      failures++;
      end_of_test;
   end
endmodule
